// ==== rtl/sah_axis.sv ====
// Per-axis homing, standstill, power-down and fault status block with AXI4-Lite registers.
// Assumes switch pins are asynchronous; position, step, encoder and fault inputs share the clock.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module sah_axis #(
  parameter int STILL_CYCLES = sah_pkg::STILL_CYC,
  parameter int PD_UNIT_CYCLES = sah_pkg::PD_UNIT_CYC
) (
  input  wire logic                       core_clk_i,
  input  wire logic                       nrst_i,
  input  wire logic                       ce_i,
  input  wire logic [sah_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic                       s_axi_awvalid_i,
  output logic                            s_axi_awready_o,
  input  wire logic [31:0]                s_axi_wdata_i,
  input  wire logic [3:0]                 s_axi_wstrb_i,
  input  wire logic                       s_axi_wvalid_i,
  output logic                            s_axi_wready_o,
  output logic [1:0]                      s_axi_bresp_o,
  output logic                            s_axi_bvalid_o,
  input  wire logic                       s_axi_bready_i,
  input  wire logic [sah_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic                       s_axi_arvalid_i,
  output logic                            s_axi_arready_o,
  output logic [31:0]                     s_axi_rdata_o,
  output logic [1:0]                      s_axi_rresp_o,
  output logic                            s_axi_rvalid_o,
  input  wire logic                       s_axi_rready_i,
  input  wire logic                       left_sw_i,
  input  wire logic                       right_sw_i,
  input  wire logic                       home_sw_i,
  input  wire logic [31:0]                position_i,
  input  wire logic                       step_pulse_i,
  input  wire logic                       motion_cmd_i,
  input  wire logic                       stall_event_i,
  input  wire logic                       deviation_event_i,
  input  wire logic [6:0]                 drv_flags_i,
  input  wire logic [9:0]                 load_i,
  input  wire logic [31:0]                absolute_angle_i,
  input  wire logic                       enc_step_i,
  input  wire logic                       enc_dir_i,
  input  wire logic                       standby_zero_i,
  output logic                            homing_busy_o,
  output logic                            homing_dir_o,
  output logic [22:0]                     homing_speed_o,
  output logic                            pos_zero_o,
  output logic                            auto_current_o,
  output logic [1:0]                      coil_mode_o,
  output logic                            current_reduce_o,
  output logic                            unit_pps_o
);
  import sah_pkg::*;

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    logic [2:0]  sync1;
    logic [2:0]  sync2;
    logic        autoscale;
    logic [7:0]  mode;
    logic [22:0] coarse;
    logic [22:0] fine;
    logic [31:0] span;
    logic [31:0] prepos;
    logic [31:0] farpos;
    logic [1:0]  free;
    logic [1:0]  merr;
    logic [31:0] enc;
    logic [31:0] pdelay;
    logic        unit;
    sah_state_t  st;
    logic        dir;
    logic [22:0] spd;
    logic        zero;
    logic [1:0]  coil;
    logic [31:0] still_cnt;
    logic        still;
    logic [31:0] tick_cnt;
    logic [31:0] pd_units;
    logic        reduce;
    logic        aw_got;
    logic [7:0]  aw_idx;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sah_regs_t;

  sah_regs_t q;
  sah_regs_t d;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ********************************************************
  // Next state
  // ********************************************************
  logic        sw_left;
  logic        sw_right;
  logic        sw_home;
  logic [5:0]  base;
  logic        target;
  logic        far_sw;
  logic        toward;
  logic        do_write;
  logic [31:0] wv;
  logic        rd_take;
  logic        start;
  logic        stop;

  always_comb
  begin
    d = q;
    sw_left = q.sync2[0];
    sw_right = q.sync2[1];
    sw_home = q.sync2[2];
    base = q.mode[5:0];
    start = 1'b0;
    stop = 1'b0;
    // Only the second stage is read to avoid metastable values
    d.sync1 = {home_sw_i, right_sw_i, left_sw_i};
    d.sync2 = q.sync1;
    d.zero = 1'b0;

    // Homing switch and direction selection
    toward = q.mode[MODE_RIGHT];
    if (base <= 6'd4)
    begin
      target = q.mode[MODE_RIGHT] ? sw_right : sw_left;
      far_sw = q.mode[MODE_RIGHT] ? sw_left : sw_right;
    end
    else
    begin
      target = sw_home ^ q.mode[MODE_INV];
      far_sw = 1'b0;
    end

    // AXI write path: address and data may come in either order
    if (s_axi_awvalid_i && !q.aw_got && !q.bvalid)
    begin
      d.aw_got = 1'b1;
      d.aw_idx = s_axi_awaddr_i[ADDR_W-1:2];
    end
    if (s_axi_wvalid_i && !q.w_got && !q.bvalid)
    begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata_i;
      d.wstrb = s_axi_wstrb_i;
    end
    do_write = q.aw_got && q.w_got && !q.bvalid;
    wv = q.wdata;
    if (do_write)
    begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      unique case (q.aw_idx)
        IDX_AUTOSCALE: if (q.wstrb[0]) d.autoscale = wv[0];
        IDX_MODE:      if (q.wstrb[0]) d.mode = wv[7:0];
        IDX_COARSE:    d.coarse = 23'(merge({9'h000, q.coarse}, wv, q.wstrb));
        IDX_FINE:      d.fine = 23'(merge({9'h000, q.fine}, wv, q.wstrb));
        IDX_COIL:      if (q.wstrb[0]) d.free = wv[1:0];
        IDX_ENC:       d.enc = merge(q.enc, wv, q.wstrb);
        IDX_PDELAY:    d.pdelay = merge(q.pdelay, wv, q.wstrb);
        IDX_UNIT:      if (q.wstrb[0]) d.unit = wv[0];
        IDX_HCTRL:
        begin
          start = q.wstrb[0] && wv[HCTRL_START];
          stop = q.wstrb[0] && wv[HCTRL_STOP];
        end
        IDX_SPAN, IDX_PREPOS, IDX_LOAD, IDX_MERR, IDX_DRV, IDX_ANGLE: ;
        default:       d.bresp = RESP_SLVERR;
      endcase
    end
    else if (q.bvalid && s_axi_bready_i)
    begin
      d.bvalid = 1'b0;
    end

    // Encoder counter; a software write takes precedence over a count
    if (!(do_write && q.aw_idx == IDX_ENC))
    begin
      if (enc_step_i)
      begin
        d.enc = enc_dir_i ? q.enc + 32'h1 : q.enc - 32'h1;
      end
    end

    // AXI read path
    rd_take = s_axi_arvalid_i && !q.rvalid;
    if (rd_take)
    begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      unique case (s_axi_araddr_i[ADDR_W-1:2])
        IDX_AUTOSCALE: d.rdata = {31'h0, q.autoscale};
        IDX_MODE:      d.rdata = {24'h0, q.mode};
        IDX_COARSE:    d.rdata = {9'h0, q.coarse};
        IDX_FINE:      d.rdata = {9'h0, q.fine};
        IDX_SPAN:      d.rdata = q.span;
        IDX_PREPOS:    d.rdata = q.prepos;
        IDX_COIL:      d.rdata = {30'h0, q.free};
        IDX_LOAD:      d.rdata = {22'h0, load_i};
        IDX_MERR:      d.rdata = {30'h0, q.merr};
        IDX_DRV:       d.rdata = {24'h0, q.still, drv_flags_i};
        IDX_ENC:       d.rdata = q.enc;
        IDX_PDELAY:    d.rdata = q.pdelay;
        IDX_ANGLE:     d.rdata = absolute_angle_i;
        IDX_HCTRL:     d.rdata = 32'h0;
        IDX_UNIT:      d.rdata = {31'h0, q.unit};
        default:
        begin
          d.rdata = 32'h0;
          d.rresp = RESP_SLVERR;
        end
      endcase
    end
    else if (q.rvalid && s_axi_rready_i)
    begin
      d.rvalid = 1'b0;
    end

    // Motion error flags: a new event wins over the clear
    if ((rd_take && s_axi_araddr_i[ADDR_W-1:2] == IDX_MERR) || motion_cmd_i || start)
    begin
      d.merr = 2'h0;
    end
    if (stall_event_i)
    begin
      d.merr[0] = 1'b1;
    end
    if (deviation_event_i)
    begin
      d.merr[1] = 1'b1;
    end

    // Homing sequence
    unique case (q.st)
      ST_IDLE:
      begin
        if (start && base >= 6'd1 && base <= 6'd8)
        begin
          unique case (base)
            6'd2, 6'd3:
            begin
              d.st = ST_FAR;
              d.dir = !toward;
            end
            6'd1, 6'd4:
            begin
              d.st = ST_COARSE;
              d.dir = toward;
            end
            6'd5, 6'd8:
            begin
              d.st = ST_COARSE;
              d.dir = 1'b0;
            end
            default:
            begin
              d.st = ST_COARSE;
              d.dir = 1'b1;
            end
          endcase
        end
      end
      ST_FAR:
      begin
        if (far_sw)
        begin
          d.farpos = position_i;
          d.st = ST_COARSE;
          d.dir = !q.dir;
        end
      end
      ST_COARSE:
      begin
        if (target)
        begin
          d.st = ST_FINE;
          d.dir = !q.dir;
        end
        else if ((base == 6'd5 || base == 6'd6) && (q.dir ? sw_right : sw_left))
        begin
          // Home search with end switches: turn at the end stop
          d.dir = !q.dir;
        end
      end
      ST_FINE:
      begin
        if (!target)
        begin
          if (base == 6'd4)
          begin
            d.st = ST_FINE2;
            d.dir = !q.dir;
          end
          else
          begin
            d.st = ST_ZERO;
          end
        end
      end
      ST_FINE2:
      begin
        if (target)
        begin
          d.st = ST_ZERO;
        end
      end
      ST_ZERO:
      begin
        d.prepos = position_i;
        d.zero = 1'b1;
        if (base == 6'd2 || base == 6'd3)
        begin
          d.span = q.farpos - position_i;
        end
        d.st = ST_IDLE;
      end
      default: d.st = ST_IDLE;
    endcase
    if (stop)
    begin
      d.st = ST_IDLE;
    end
    unique case (d.st)
      ST_FAR, ST_COARSE: d.spd = q.coarse;
      ST_FINE, ST_FINE2: d.spd = q.fine;
      default:           d.spd = 23'h0;
    endcase

    // Standstill detection and power-down delay
    if (step_pulse_i)
    begin
      d.still_cnt = 32'h0;
      d.still = 1'b0;
      d.tick_cnt = 32'h0;
      d.pd_units = 32'h0;
    end
    else
    begin
      if (q.still_cnt == 32'(STILL_CYCLES - 1))
      begin
        d.still = 1'b1;
      end
      else
      begin
        d.still_cnt = q.still_cnt + 32'h1;
      end
      if (q.tick_cnt == 32'(PD_UNIT_CYCLES - 1))
      begin
        d.tick_cnt = 32'h0;
        // Saturate so a long stop never wraps back to full current
        if (q.pd_units != 32'hffff_ffff)
        begin
          d.pd_units = q.pd_units + 32'h1;
        end
      end
      else
      begin
        d.tick_cnt = q.tick_cnt + 32'h1;
      end
    end
    d.reduce = !step_pulse_i && (d.pd_units >= q.pdelay);
    d.coil = (standby_zero_i && q.reduce) ? q.free : 2'h0;
  end

  // ********************************************************
  // Registers
  // ********************************************************
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      q <= '0;
      q.mode <= RST_MODE;
      q.pdelay <= RST_PDELAY;
      q.unit <= RST_UNIT;
      q.st <= ST_IDLE;
    end
    else if (ce_i)
    begin
      q <= d;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign s_axi_awready_o = ce_i && !q.aw_got && !q.bvalid;
  assign s_axi_wready_o = ce_i && !q.w_got && !q.bvalid;
  assign s_axi_bvalid_o = q.bvalid;
  assign s_axi_bresp_o = q.bresp;
  assign s_axi_arready_o = ce_i && !q.rvalid;
  assign s_axi_rvalid_o = q.rvalid;
  assign s_axi_rdata_o = q.rdata;
  assign s_axi_rresp_o = q.rresp;
  assign homing_busy_o = q.st != ST_IDLE;
  assign homing_dir_o = q.dir;
  assign homing_speed_o = q.spd;
  assign pos_zero_o = q.zero;
  assign auto_current_o = q.autoscale;
  assign coil_mode_o = q.coil;
  assign current_reduce_o = q.reduce;
  assign unit_pps_o = q.unit;
endmodule // sah_axis

// ==== rtl/sah_pkg.sv ====
// Constants, types and register map of the stepper axis homing and fault status block.
// Assumes one 100 MHz clock and an AXI4-Lite master on the register side.
// Summary of operation
// - Autoscale 0 uses user PWM amplitude; 1 selects automatic current control.
// - Homing mode 1 searches the left switch; mode 4 approaches it from both sides.
// - Modes 7 and 8 search home switch, positive or negative, ignoring end switches.
// - Mode plus 128 inverts home switch polarity for modes 5 to 8.
// - Mode plus 64 searches the right switch instead of left in modes 1 to 4.
// - Coarse homing phase moves at the programmed coarse search speed.
// - Modes 2 and 3 yield the signed distance between both end switches.
// - Position before zeroing during homing is saved to a read-only register.
// - Standby current zero at standstill applies the selected coil option 0 to 3.
// - Current load measurement is readable as unsigned 0 to 1023.
// - Motion error status: value 1 stall error, value 2 position deviation error.
// - Motion error flags clear on status read or on a motion command.
// - Driver status bits 0..2: stall, overtemperature shutdown, temperature pre-warning.
// - Driver status bits 3 and 4: short to ground on coil A or B.
// - Driver status bits 5 and 6: open load on coil A or B.
// - Driver status bit 7: no step pulse during the last 2^20 clock cycles.
// - After power-down delay in 10 ms units, current ramps down to standby.
// - Absolute angle within one motor rotation is readable as read-only value.
// - Unit mode 0 internal units, 1 pulses per second; default 1.
package sah_pkg;
  localparam int          ADDR_W        = 10;
  localparam int          CLK_HZ        = 100_000_000;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_AUTOSCALE = 8'hc0;
  localparam logic [7:0]  IDX_MODE      = 8'hc1;
  localparam logic [7:0]  IDX_COARSE    = 8'hc2;
  localparam logic [7:0]  IDX_FINE      = 8'hc3;
  localparam logic [7:0]  IDX_SPAN      = 8'hc4;
  localparam logic [7:0]  IDX_PREPOS    = 8'hc5;
  localparam logic [7:0]  IDX_COIL      = 8'hcc;
  localparam logic [7:0]  IDX_LOAD      = 8'hce;
  localparam logic [7:0]  IDX_MERR      = 8'hcf;
  localparam logic [7:0]  IDX_DRV       = 8'hd0;
  localparam logic [7:0]  IDX_ENC       = 8'hd1;
  localparam logic [7:0]  IDX_PDELAY    = 8'hd6;
  localparam logic [7:0]  IDX_ANGLE     = 8'hd7;
  localparam logic [7:0]  IDX_HCTRL     = 8'he0;
  localparam logic [7:0]  IDX_UNIT      = 8'hff;
  // Homing control bits
  localparam int          HCTRL_START   = 0;
  localparam int          HCTRL_STOP    = 1;
  // Mode field layout
  localparam int          MODE_RIGHT    = 6;
  localparam int          MODE_INV      = 7;
  // Reset values
  localparam logic [31:0] RST_PDELAY    = 32'h0000_00c8;
  localparam logic        RST_UNIT      = 1'h1;
  localparam logic [7:0]  RST_MODE      = 8'h01;
  // Timing and AXI response codes
  localparam int          STILL_CYC     = 1 << 20;
  localparam int          PD_UNIT_MS    = 10;
  localparam int          PD_UNIT_CYC   = (CLK_HZ / 1000) * PD_UNIT_MS;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_FAR    = 3'b001,
    ST_COARSE = 3'b010,
    ST_FINE   = 3'b011,
    ST_FINE2  = 3'b100,
    ST_ZERO   = 3'b101
  } sah_state_t;
endpackage

// ==== verification/sah_axis_monitor.sv ====
// Concurrent checks on the ports of the axis homing and status block.
// Assumes an AXI4-Lite master that keeps the channel rules.
`timescale 1ns/1ps
module sah_axis_monitor (
  input wire logic        core_clk_i,
  input wire logic        nrst_i,
  input wire logic        ce_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        step_pulse_i,
  input wire logic        standby_zero_i,
  input wire logic        homing_busy_o,
  input wire logic        pos_zero_o,
  input wire logic        auto_current_o,
  input wire logic [1:0]  coil_mode_o,
  input wire logic        current_reduce_o
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  zero_ends_busy_a: assert property (pos_zero_o |-> !homing_busy_o && $past(homing_busy_o))
    else $error("zero pulse not at end of homing");
  zero_pulse_a: assert property (pos_zero_o |=> !pos_zero_o)
    else $error("zero pulse longer than one cycle");
  busy_start_a: assert property ($rose(homing_busy_o) |-> s_axi_bvalid_o)
    else $error("homing started without a write");
  bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
  read_answer_a: assert property (ce_i && s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  coil_gate_a: assert property (!standby_zero_i |=> coil_mode_o == 2'h0)
    else $error("coil option without zero standby");
  step_wakes_a: assert property (step_pulse_i |-> ##[1:2] !current_reduce_o)
    else $error("current stays reduced after step");
  autoscale_wr_a: assert property ($changed(auto_current_o)
    |-> s_axi_bvalid_o || $past(s_axi_bvalid_o))
    else $error("autoscale changed without write");
  cover property (pos_zero_o);
  cover property ($rose(current_reduce_o));
  cover property (coil_mode_o == 2'h2);
endmodule // sah_axis_monitor
bind sah_axis sah_axis_monitor i_sah_axis_monitor (.*);

// ==== verification/sah_motor_model.sv ====
// Motor, reference switches and position counter seen by the axis block.
// Assumes one step per clock while homing runs at a nonzero speed.
`timescale 1ns/1ps
module sah_motor_model (
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        busy_i,
  input  wire logic        dir_i,
  input  wire logic [22:0] speed_i,
  input  wire logic        zero_i,
  output logic [31:0]      position_o,
  output logic             left_sw_o,
  output logic             right_sw_o,
  output logic             home_sw_o,
  output logic             step_o
);
  // ****************************************
  // Mechanics
  // ****************************************
  // Zeroing moves the counter origin, never the switches
  logic signed [31:0] phys_q;
  logic signed [31:0] org_q;
  assign step_o     = busy_i && (speed_i != 23'h0);
  assign position_o = phys_q - org_q;
  assign left_sw_o  = phys_q <= -20;
  assign right_sw_o = phys_q >= 20;
  // Home cam on both sides so either direction finds it
  assign home_sw_o  = (phys_q >= 10 && phys_q <= 13) || (phys_q >= -13 && phys_q <= -10);
  always_ff @(posedge core_clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      phys_q <= '0;
      org_q  <= '0;
    end
    else
    begin
      if (zero_i)
        org_q <= phys_q;
      if (step_o)
        phys_q <= dir_i ? phys_q + 1 : phys_q - 1;
    end
endmodule // sah_motor_model

// ==== verification/tb_top.sv ====
// Self-checking bench of the axis block with a motor model on the far side.
// Assumes the package register map and shortened standstill counts.
`timescale 1ns/1ps
module tb_top;
  import sah_pkg::*;
  logic        core_clk_i, nrst_i, ce_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
  logic        s_axi_arvalid_i, s_axi_rready_i, left_sw_i, right_sw_i, home_sw_i, motion_cmd_i;
  logic        stall_event_i, deviation_event_i, enc_step_i, enc_dir_i, standby_zero_i, tb_step;
  logic        mdl_step, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic        s_axi_rvalid_o, homing_busy_o, homing_dir_o, pos_zero_o, auto_current_o;
  logic        current_reduce_o, unit_pps_o;
  logic [9:0]  s_axi_awaddr_i, s_axi_araddr_i, load_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, position_i, absolute_angle_i;
  logic [3:0]  s_axi_wstrb_i;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, coil_mode_o;
  logic [22:0] homing_speed_o;
  logic [6:0]  drv_flags_i;
  wire logic   step_pulse_i = tb_step | mdl_step;
  int          num_errors, num_checks;

  sah_axis #(.STILL_CYCLES(16), .PD_UNIT_CYCLES(8)) i_sah_axis (.*);
  sah_motor_model i_sah_motor_model (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .busy_i(homing_busy_o), .dir_i(homing_dir_o), .speed_i(homing_speed_o),
    .zero_i(pos_zero_o), .position_o(position_i), .left_sw_o(left_sw_i),
    .right_sw_o(right_sw_i), .home_sw_o(home_sw_i), .step_o(mdl_step));

  // ****************************************
  // Bus and check tasks
  // ****************************************
  function automatic logic [9:0] ad(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Handshakes are judged mid-cycle, where nothing the bench drives moves
  task automatic wr(input logic [9:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tv;
    @(posedge core_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    forever
    begin
      @(negedge core_clk_i);
      ta = s_axi_awvalid_i && s_axi_awready_o;
      tw = s_axi_wvalid_i && s_axi_wready_o;
      tv = s_axi_bvalid_o;
      r = s_axi_bresp_o;
      @(posedge core_clk_i);
      if (ta)
        s_axi_awvalid_i <= 1'b0;
      if (tw)
        s_axi_wvalid_i <= 1'b0;
      if (tv)
      begin
        s_axi_bready_i <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tv;
    @(posedge core_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    forever
    begin
      @(negedge core_clk_i);
      ta = s_axi_arvalid_i && s_axi_arready_o;
      tv = s_axi_rvalid_o;
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
      @(posedge core_clk_i);
      if (ta)
        s_axi_arvalid_i <= 1'b0;
      if (tv)
      begin
        s_axi_rready_i <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(ad(idx), d, r);
    chk(nm, e, d);
  endtask

  // Bits: encoder step, motor step, motion command, deviation, stall
  task automatic ev(input logic [4:0] m);
    @(posedge core_clk_i);
    {enc_step_i, tb_step, motion_cmd_i, deviation_event_i, stall_event_i} <= m;
    @(posedge core_clk_i);
    {enc_step_i, tb_step, motion_cmd_i, deviation_event_i, stall_event_i} <= 5'h0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    logic [1:0]  r;
    logic [31:0] d;
    rdc("mode", IDX_MODE, 32'h1);
    rdc("pdelay", IDX_PDELAY, 32'hc8);
    rdc("unit", IDX_UNIT, 32'h1);
    chk("unit_pps", 32'h1, unit_pps_o);
    wr(ad(IDX_AUTOSCALE), 32'h1, r);
    rdc("autoscale", IDX_AUTOSCALE, 32'h1);
    chk("auto_on", 32'h1, auto_current_o);
    wr(ad(IDX_AUTOSCALE), 32'h0, r);
    rdc("autoscale", IDX_AUTOSCALE, 32'h0);
    chk("auto_off", 32'h0, auto_current_o);
    wr(ad(IDX_UNIT), 32'h0, r);
    rdc("unit", IDX_UNIT, 32'h0);
    chk("unit_int", 32'h0, unit_pps_o);
    wr(ad(IDX_UNIT), 32'h1, r);
    wr(ad(IDX_COARSE), 32'hffff_ffff, r);
    rdc("coarse", IDX_COARSE, 32'h007f_ffff);
    wr(ad(IDX_SPAN), 32'h0000_ffff, r);
    chk("ro_resp", RESP_OKAY, r);
    rdc("span_ro", IDX_SPAN, 32'h0);
    wr(10'h3f0, 32'h5, r);
    chk("bad_wr", RESP_SLVERR, r);
    rd(10'h3f0, d, r);
    chk("bad_rd", RESP_SLVERR, r);
    chk("bad_data", 32'h0, d);
    $display("test regs done");
  endtask

  task automatic t_status;
    load_i <= 10'h3ff;
    drv_flags_i <= 7'h55;
    absolute_angle_i <= 32'h1234_5678;
    repeat (20) @(posedge core_clk_i);
    rdc("load", IDX_LOAD, 32'h3ff);
    rdc("drv_still", IDX_DRV, 32'hd5);
    rdc("angle", IDX_ANGLE, 32'h1234_5678);
    drv_flags_i <= 7'h2a;
    ev(5'h08);
    rdc("drv_moved", IDX_DRV, 32'h2a);
    ev(5'h01);
    rdc("merr_stall", IDX_MERR, 32'h1);
    rdc("merr_clr", IDX_MERR, 32'h0);
    ev(5'h02);
    rdc("merr_dev", IDX_MERR, 32'h2);
    ev(5'h03);
    ev(5'h04);
    rdc("merr_cmd", IDX_MERR, 32'h0);
    ev(5'h03);
    rdc("merr_both", IDX_MERR, 32'h3);
    $display("test status done");
  endtask

  task automatic t_pdown;
    logic [1:0] r;
    wr(ad(IDX_PDELAY), 32'h2, r);
    standby_zero_i <= 1'b1;
    ev(5'h08);
    repeat (16) @(negedge core_clk_i);
    chk("reduce_early", 32'h0, current_reduce_o);
    repeat (1) @(negedge core_clk_i);
    chk("reduce_late", 32'h1, current_reduce_o);
    for (int c = 0; c < 4; c++)
    begin
      wr(ad(IDX_COIL), c, r);
      repeat (3) @(negedge core_clk_i);
      chk("coil_mode", c, coil_mode_o);
    end
    @(posedge core_clk_i);
    standby_zero_i <= 1'b0;
    repeat (3) @(negedge core_clk_i);
    chk("coil_off", 32'h0, coil_mode_o);
    wr(ad(IDX_ENC), 32'd100, r);
    enc_dir_i <= 1'b1;
    repeat (3) ev(5'h10);
    enc_dir_i <= 1'b0;
    ev(5'h10);
    rdc("encoder", IDX_ENC, 32'd102);
    $display("test power down done");
  endtask

  task automatic t_homing;
    logic [7:0]  md [7] = '{8'h07, 8'h87, 8'h41, 8'h08, 8'h01, 8'h02, 8'h04};
    int          sg [7] = '{2, 1, 2, 0, 1, 3, 1};
    logic [31:0] d;
    logic [31:0] s;
    logic [1:0]  r;
    logic        sc;
    logic        sf;
    wr(ad(IDX_COARSE), 32'd100, r);
    wr(ad(IDX_FINE), 32'd10, r);
    foreach (md[i])
    begin
      wr(ad(IDX_MODE), md[i], r);
      sc = 1'b0;
      sf = 1'b0;
      // Coarse may last one cycle
      fork
        wr(ad(IDX_HCTRL), 32'h1, r);
        for (int n = 0; n < 400 && pos_zero_o !== 1'b1; n++)
        begin
          @(negedge core_clk_i);
          if (homing_speed_o === 23'd100)
            sc = 1'b1;
          if (homing_speed_o === 23'd10 && sc)
            sf = 1'b1;
        end
      join
      chk("zeroed", 32'h1, pos_zero_o);
      chk("speeds", 32'h3, {sc, sf});
      rd(ad(IDX_PREPOS), d, r);
      if (sg[i] == 1)
        chk("pre_neg", 32'h1, d[31]);
      if (sg[i] == 2)
        chk("pre_pos", 32'h0, d[31]);
      if (sg[i] == 3)
      begin
        rd(ad(IDX_SPAN), s, r);
        s = s[31] ? -s : s;
        chk("span", 32'h1, s > 30 && s < 50);
      end
    end
    wr(ad(IDX_HCTRL), 32'h1, r);
    chk("started", 32'h1, homing_busy_o);
    wr(ad(IDX_HCTRL), 32'h2, r);
    chk("stopped", 32'h0, homing_busy_o);
    $display("test homing done");
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  initial
  begin
    #200000;
    num_errors++;
    complete_run;
  end

  initial
  begin
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
    {motion_cmd_i, stall_event_i, deviation_event_i, enc_step_i, enc_dir_i, tb_step} = '0;
    {standby_zero_i, s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, load_i} = '0;
    {drv_flags_i, absolute_angle_i} = '0;
    s_axi_wstrb_i = 4'hf;
    ce_i = 1'b1;
    nrst_i = 1'b0;
    num_errors = 0;
    num_checks = 0;
    repeat (6) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    t_regs;
    t_status;
    t_pdown;
    t_homing;
    complete_run;
  end
endmodule // tb_top
